// File: hw/smch_pkg.sv
package smch_pkg;

    // Service classes
    typedef enum logic [2:0] {
        SMCH_RX_ONLY,
        SMCH_TX_ONLY,
        SMCH_HALF_DUPLEX,
        SMCH_FULL_DUPLEX,
        SMCH_MULTIPOINT
    } smch_service_t;

    // Register offsets
    localparam logic [3:0] SMCH_REG_CTRL   = 4'h0;
    localparam logic [3:0] SMCH_REG_DIV    = 4'h1;
    localparam logic [3:0] SMCH_REG_TXDATA = 4'h2;
    localparam logic [3:0] SMCH_REG_STATUS = 4'h3;
    localparam logic [3:0] SMCH_REG_RXDATA = 4'h4;

    // Control fields
    localparam int SMCH_CTRL_SVC_LSB  = 0;
    localparam int SMCH_CTRL_RTS_HOLD = 3;
    localparam int SMCH_CTRL_ENABLE   = 4;

    // Reset values and mark byte
    localparam logic [15:0] SMCH_DIV_RESET  = 16'h01B2;
    localparam logic [2:0]  SMCH_SVC_RESET  = 3'h3;
    localparam logic [7:0]  SMCH_MARK_BYTE  = 8'hFF;

    // Character framing
    localparam int SMCH_DATA_BITS  = 8;
    localparam int SMCH_FRAME_BITS = 10;

    // Status bit positions
    localparam int SMCH_ST_CTS      = 0;
    localparam int SMCH_ST_DSR      = 1;
    localparam int SMCH_ST_TX_BUSY  = 2;
    localparam int SMCH_ST_TX_FULL  = 3;
    localparam int SMCH_ST_RX_VALID = 4;
    localparam int SMCH_ST_DSR_DROP = 5;
    localparam int SMCH_ST_RTS      = 6;

    // Modem-side lines
    typedef struct packed {
        logic txd;
        logic rts;
    } smch_line_out_t;

    typedef struct packed {
        logic rxd;
        logic cts;
        logic dsr;
    } smch_line_in_t;

    // Register bus request
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } smch_bus_req_t;

endpackage

// File: hw/smch_sync.sv
`timescale 1ns/1ps

module smch_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } smch_sync_state_t;

    smch_sync_state_t st;
    smch_sync_state_t next_st;

    always_comb begin
        next_st        = st;
        next_st.meta   = async_in;
        next_st.stable = st.meta;
    end

    // Idle lines reset to mark / on
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{meta: '1, stable: '1};
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;

endmodule

// File: hw/smch_top.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module smch_top (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Register port
    input  wire smch_pkg::smch_bus_req_t bus_req,
    output logic [15:0]                rdata,
    // Modem lines
    input  wire smch_pkg::smch_line_in_t line_in,
    output smch_pkg::smch_line_out_t   line_out
);

    typedef enum logic [1:0] {
        SMCH_TX_IDLE,
        SMCH_TX_WAIT,
        SMCH_TX_SHIFT
    } smch_tx_state_t;

    typedef enum logic [1:0] {
        SMCH_RX_IDLE,
        SMCH_RX_START,
        SMCH_RX_DATA,
        SMCH_RX_STOP
    } smch_rx_state_t;

    typedef struct packed {
        logic [2:0]     svc;
        logic           rts_hold;
        logic           enable;
        logic [15:0]    div;
        logic [7:0]     tx_buf;
        logic           tx_full;
        smch_tx_state_t tx_st;
        logic [9:0]     tx_sh;
        logic [3:0]     tx_cnt;
        logic [15:0]    tx_div;
        smch_rx_state_t rx_st;
        logic [7:0]     rx_sh;
        logic [3:0]     rx_cnt;
        logic [15:0]    rx_div;
        logic [7:0]     rx_data;
        logic           rx_valid;
        logic           dsr_prev;
        logic           dsr_drop;
        logic           txd;
        logic           rts;
        logic [15:0]    rdata;
    } smch_state_t;

    smch_state_t             st;
    smch_state_t             next_st;
    logic [2:0]              sync_lines;
    smch_pkg::smch_line_in_t line_s;

    smch_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (line_in),
        .sync_out (sync_lines)
    );

    assign line_s = smch_pkg::smch_line_in_t'(sync_lines);

    function automatic logic is_svc(input logic [2:0] v, input smch_pkg::smch_service_t s);
        is_svc = (v == 3'(s));
    endfunction

    function automatic logic [15:0] status_word(input smch_state_t s,
                                                input smch_pkg::smch_line_in_t l);
        logic [15:0] w;
        w = 16'h0000;
        w[smch_pkg::SMCH_ST_CTS]      = l.cts;
        w[smch_pkg::SMCH_ST_DSR]      = l.dsr;
        w[smch_pkg::SMCH_ST_TX_BUSY]  = (s.tx_st != SMCH_TX_IDLE);
        w[smch_pkg::SMCH_ST_TX_FULL]  = s.tx_full;
        w[smch_pkg::SMCH_ST_RX_VALID] = s.rx_valid;
        w[smch_pkg::SMCH_ST_DSR_DROP] = s.dsr_drop;
        w[smch_pkg::SMCH_ST_RTS]      = s.rts;
        status_word = w;
    endfunction

    function automatic logic at_zero(input logic [15:0] v);
        at_zero = (v == 16'h0000);
    endfunction

    function automatic logic [15:0] count_down(input logic [15:0] v);
        count_down = v - 16'h0001;
    endfunction

    function automatic logic [15:0] half_bit(input logic [15:0] v);
        half_bit = {1'b0, v[15:1]};
    endfunction

    function automatic logic [9:0] frame_word(input logic [7:0] d);
        frame_word = {1'b1, d, 1'b0};
    endfunction

    logic rx_only;
    logic may_hold;
    logic dsr_fall;
    assign rx_only  = is_svc(st.svc, smch_pkg::SMCH_RX_ONLY);
    assign may_hold = is_svc(st.svc, smch_pkg::SMCH_TX_ONLY)
                    | is_svc(st.svc, smch_pkg::SMCH_FULL_DUPLEX);
    assign dsr_fall = st.dsr_prev & ~line_s.dsr;

    always_comb begin
        next_st          = st;
        next_st.dsr_prev = line_s.dsr;
        next_st.rdata    = 16'h0000;

        // Register writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                smch_pkg::SMCH_REG_CTRL: begin
                    next_st.svc      = bus_req.wdata[smch_pkg::SMCH_CTRL_SVC_LSB +: 3];
                    next_st.rts_hold = bus_req.wdata[smch_pkg::SMCH_CTRL_RTS_HOLD];
                    next_st.enable   = bus_req.wdata[smch_pkg::SMCH_CTRL_ENABLE];
                end
                smch_pkg::SMCH_REG_DIV: begin
                    next_st.div = bus_req.wdata;
                end
                smch_pkg::SMCH_REG_TXDATA: begin
                    if (!st.tx_full) begin
                        next_st.tx_buf  = bus_req.wdata[smch_pkg::SMCH_DATA_BITS-1:0];
                        next_st.tx_full = 1'b1;
                    end
                end
                smch_pkg::SMCH_REG_STATUS: begin
                    if (bus_req.wdata[smch_pkg::SMCH_ST_DSR_DROP]) begin
                        next_st.dsr_drop = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                smch_pkg::SMCH_REG_CTRL: begin
                    next_st.rdata[smch_pkg::SMCH_CTRL_SVC_LSB +: 3] = st.svc;
                    next_st.rdata[smch_pkg::SMCH_CTRL_RTS_HOLD]     = st.rts_hold;
                    next_st.rdata[smch_pkg::SMCH_CTRL_ENABLE]       = st.enable;
                end
                smch_pkg::SMCH_REG_DIV:    next_st.rdata = st.div;
                smch_pkg::SMCH_REG_STATUS: next_st.rdata = status_word(st, line_s);
                smch_pkg::SMCH_REG_RXDATA: begin
                    next_st.rdata    = {8'h00, st.rx_data};
                    next_st.rx_valid = 1'b0;
                end
                default: next_st.rdata = 16'h0000;
            endcase
        end

        if (dsr_fall) begin
            next_st.dsr_drop = 1'b1;
        end

        // Transmitter
        unique case (st.tx_st)
            SMCH_TX_IDLE: begin
                next_st.txd = 1'b1;
                if (st.tx_full && st.enable && !rx_only) begin
                    next_st.tx_st = SMCH_TX_WAIT;
                end
            end
            SMCH_TX_WAIT: begin
                next_st.txd = 1'b1;
                if (rx_only || !st.enable) begin
                    next_st.tx_st = SMCH_TX_IDLE;
                end else if (line_s.cts && line_s.dsr && st.rts) begin
                    next_st.tx_sh   = frame_word(st.tx_buf);
                    next_st.tx_full = 1'b0;
                    next_st.tx_cnt  = 4'(smch_pkg::SMCH_FRAME_BITS);
                    next_st.tx_div  = 16'h0000;
                    next_st.txd     = 1'b0;
                    next_st.tx_st   = SMCH_TX_SHIFT;
                end
            end
            SMCH_TX_SHIFT: begin
                next_st.txd = st.tx_sh[0];
                if (st.tx_div == st.div) begin
                    next_st.tx_div = 16'h0000;
                    next_st.tx_sh  = {1'b1, st.tx_sh[9:1]};
                    next_st.tx_cnt = st.tx_cnt - 4'h1;
                    if (st.tx_cnt == 4'h1) begin
                        next_st.txd   = 1'b1;
                        next_st.tx_st = SMCH_TX_IDLE;
                    end else begin
                        next_st.txd = st.tx_sh[1];
                    end
                end else begin
                    next_st.tx_div = st.tx_div + 16'h0001;
                end
            end
            default: next_st.tx_st = SMCH_TX_IDLE;
        endcase
        if (rx_only) begin
            next_st.txd = 1'b1;
        end

        // Request to send
        if (rx_only) begin
            next_st.rts = 1'b0;
        end else if (may_hold && st.rts_hold && st.enable) begin
            next_st.rts = 1'b1;
        end else begin
            next_st.rts = (next_st.tx_st != SMCH_TX_IDLE)
                        | (next_st.tx_full & st.enable);
        end

        // Receiver, mid-element sampling
        unique case (st.rx_st)
            SMCH_RX_IDLE: begin
                if (!line_s.rxd) begin
                    next_st.rx_div = half_bit(st.div);
                    next_st.rx_st  = SMCH_RX_START;
                end
            end

            SMCH_RX_START: begin
                if (at_zero(st.rx_div)) begin
                    next_st.rx_div = st.div;
                    next_st.rx_cnt = 4'(smch_pkg::SMCH_DATA_BITS);
                    next_st.rx_st  = line_s.rxd ? SMCH_RX_IDLE : SMCH_RX_DATA;
                end else begin
                    next_st.rx_div = count_down(st.rx_div);
                end
            end

            SMCH_RX_DATA: begin
                if (at_zero(st.rx_div)) begin
                    next_st.rx_div = st.div;
                    next_st.rx_sh  = {line_s.rxd, st.rx_sh[7:1]};
                    next_st.rx_cnt = st.rx_cnt - 4'h1;
                    if (st.rx_cnt == 4'h1) begin
                        next_st.rx_st = SMCH_RX_STOP;
                    end
                end else begin
                    next_st.rx_div = count_down(st.rx_div);
                end
            end

            SMCH_RX_STOP: begin
                if (at_zero(st.rx_div)) begin
                    if (line_s.rxd) begin
                        next_st.rx_data  = st.rx_sh;
                        next_st.rx_valid = 1'b1;
                    end
                    next_st.rx_st = SMCH_RX_IDLE;
                end else begin
                    next_st.rx_div = count_down(st.rx_div);
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st          <= '0;
            st.svc      <= smch_pkg::SMCH_SVC_RESET;
            st.div      <= smch_pkg::SMCH_DIV_RESET;
            st.tx_st    <= SMCH_TX_IDLE;
            st.rx_st    <= SMCH_RX_IDLE;
            st.txd      <= 1'b1;
            st.dsr_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata        = st.rdata;
    assign line_out = '{
        txd: st.txd,
        rts: st.rts
    };

endmodule

// File: bench/smch_modem_model.sv
`timescale 1ns/1ps

module smch_modem_model (
    // Clock
    input  wire logic                     clk,
    // Terminal side
    input  wire smch_pkg::smch_line_out_t term,
    output smch_pkg::smch_line_in_t       lines,
    // Modes
    input  wire logic                     ready,
    input  wire logic                     no_tx
);
    logic [2:0] dly = 3'h0;
    logic       carrier;

    // Carrier follows request to send
    assign carrier = term.rts;

    // Channel set-up delay
    always @(posedge clk) begin
        dly <= carrier ? {dly[1:0], 1'b1} : 3'h0;
    end
    assign lines = '{
        rxd: no_tx | term.txd,
        cts: dly[2] & ~no_tx,
        dsr: ready
    };
endmodule

// File: bench/smch_top_sva.sv
`timescale 1ns/1ps

module smch_top_sva (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     sys_rst,
    // Register port
    input wire smch_pkg::smch_bus_req_t  bus_req,
    input wire logic [15:0]              rdata,
    // Modem lines
    input wire smch_pkg::smch_line_in_t  line_in,
    input wire smch_pkg::smch_line_out_t line_out
);
    logic [2:0]  svc;
    logic [2:0]  svc_q;
    logic [15:0] div;
    logic [15:0] run;
    logic        en;
    logic        last;
    logic        rxo;
    logic        txw;

    assign rxo = (svc == 3'h0) && (svc_q == 3'h0);
    assign txw = bus_req.wr && (bus_req.addr == smch_pkg::SMCH_REG_TXDATA);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            svc <= smch_pkg::SMCH_SVC_RESET;
            svc_q <= smch_pkg::SMCH_SVC_RESET;
            div <= smch_pkg::SMCH_DIV_RESET;
            en <= 1'b0;
            run <= 16'hFFFF;
            last <= 1'b1;
        end else begin
            svc_q <= svc;
            last <= line_out.txd;
            run <= (line_out.txd != last) ? 16'h1 : run + {15'h0, run != 16'hFFFF};
            if (bus_req.wr && bus_req.addr == smch_pkg::SMCH_REG_CTRL) begin
                svc <= bus_req.wdata[2:0];
                en <= bus_req.wdata[4];
            end
            if (bus_req.wr && bus_req.addr == smch_pkg::SMCH_REG_DIV) begin
                div <= bus_req.wdata;
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_start;
        $fell(line_out.txd);
    endsequence

    a_rts_rx_only: assert property (rxo |-> !line_out.rts)
        else $error("rts on in receive-only");
    a_txd_rx_only: assert property (rxo |-> line_out.txd)
        else $error("txd left mark in receive-only");
    a_idle_mark: assert property (!line_out.rts |-> line_out.txd)
        else $error("txd space while idle");
    a_frame_rts: assert property (!line_out.txd |-> line_out.rts)
        else $error("rts dropped in frame");
    a_start_rts: assert property (s_start |-> $past(line_out.rts, 2))
        else $error("start bit without prior rts");
    a_start_clear: assert property (
        s_start |-> $past(line_in.cts, 3) && $past(line_in.dsr, 3))
        else $error("start bit before synced cts and dsr");
    a_bit_hold: assert property (line_out.txd != last |-> run >= div + 16'h1)
        else $error("bit element cut short");
    a_rts_request: assert property (
        txw && en && svc != 3'h0 && !line_out.rts |-> ##[1:3] line_out.rts)
        else $error("rts not raised for queued data");
endmodule

bind smch_top smch_top_sva u_smch_top_sva (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rdata(rdata), .line_in(line_in), .line_out(line_out));

// File: bench/smch_top_tb_top.sv
`timescale 1ns/1ps

module smch_top_tb_top;
    logic                     clk = 1'b0;
    logic                     sys_rst = 1'b1;
    logic                     ready = 1'b1;
    logic                     no_tx = 1'b0;
    logic [15:0]              rdata;
    logic [15:0]              got;
    logic [7:0]               pat [5] = '{8'h0, 8'hA5, 8'h3C, 8'h01, 8'hFE};
    int                       err_total = 0;
    int                       checks = 0;
    smch_pkg::smch_bus_req_t  bus_req = '0;
    smch_pkg::smch_line_in_t  line_in;
    smch_pkg::smch_line_out_t line_out;

    always #10 clk = ~clk;

    smch_top u_smch_top (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
        .line_in(line_in), .line_out(line_out));
    smch_modem_model u_smch_modem_model (.clk(clk), .term(line_out), .lines(line_in),
        .ready(ready), .no_tx(no_tx));

    task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 got = rdata;
    endtask

    task automatic wait_rx;
        for (int i = 0; i < 100; i++) begin
            rd(smch_pkg::SMCH_REG_STATUS);
            if (got[smch_pkg::SMCH_ST_RX_VALID] === 1'b1) break;
        end
    endtask

    task automatic results;
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        err_total++;
        results();
    end

    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values and unmapped place
        rd(smch_pkg::SMCH_REG_CTRL);
        cmp(got, 16'h0003);
        rd(smch_pkg::SMCH_REG_DIV);
        cmp(got, smch_pkg::SMCH_DIV_RESET);
        wr(4'h9, 16'hFFFF);
        rd(4'h9);
        cmp(got, 16'h0000);
        rd(smch_pkg::SMCH_REG_STATUS);
        cmp(got & 16'h007F, 16'h0002);
        cmp({14'h0, line_out}, 16'h0002);
        wr(smch_pkg::SMCH_REG_DIV, 16'h0003);
        // One character in every sending class, second write refused
        for (int s = 1; s < 5; s++) begin
            wr(smch_pkg::SMCH_REG_CTRL, {11'h0, 1'b1, 1'b0, 3'(s)});
            wr(smch_pkg::SMCH_REG_TXDATA, {8'h0, pat[s]});
            wr(smch_pkg::SMCH_REG_TXDATA, {8'h0, ~pat[s]});
            wait_rx();
            rd(smch_pkg::SMCH_REG_RXDATA);
            cmp(got, {8'h0, pat[s]});
            repeat (60) @(posedge clk);
            rd(smch_pkg::SMCH_REG_STATUS);
            cmp(got & 16'h007F, 16'h0002);
        end
        // Held request to send in transmit-only
        wr(smch_pkg::SMCH_REG_CTRL, 16'h0019);
        repeat (10) @(posedge clk);
        cmp({14'h0, line_out}, 16'h0003);
        wr(smch_pkg::SMCH_REG_TXDATA, 16'h005A);
        wait_rx();
        rd(smch_pkg::SMCH_REG_RXDATA);
        cmp(got, 16'h005A);
        repeat (10) @(posedge clk);
        rd(smch_pkg::SMCH_REG_STATUS);
        cmp(got & 16'h007F, 16'h0043);
        // Receive-only keeps both lines quiet
        @(posedge clk);
        no_tx <= 1'b1;
        wr(smch_pkg::SMCH_REG_CTRL, 16'h0010);
        wr(smch_pkg::SMCH_REG_TXDATA, 16'h000F);
        repeat (60) @(posedge clk);
        cmp({14'h0, line_out}, 16'h0002);
        // Data set ready alone does not start a frame
        wr(smch_pkg::SMCH_REG_CTRL, 16'h0013);
        wr(smch_pkg::SMCH_REG_TXDATA, 16'h0055);
        repeat (60) @(posedge clk);
        cmp({14'h0, line_out}, 16'h0003);
        // Data set ready drop is latched and cleared
        @(posedge clk);
        ready <= 1'b0;
        repeat (6) @(posedge clk);
        rd(smch_pkg::SMCH_REG_STATUS);
        cmp(got & 16'h002E, 16'h002C);
        @(posedge clk);
        ready <= 1'b1;
        repeat (4) @(posedge clk);
        wr(smch_pkg::SMCH_REG_STATUS, 16'h0020);
        rd(smch_pkg::SMCH_REG_STATUS);
        cmp(got & 16'h002E, 16'h000E);
        results();
    end
endmodule
